// ===== logic/cas_pkg.sv
// Shared constants, operation codes and carriers for the CPU ALU and status datapath
package cas_pkg;

  // Datapath geometry
  localparam int DATA_W = 16;
  localparam int SHAMT_W = 4;
  localparam int LIT_W = 5;

  // Status register field positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_WRAP = 2;
  localparam int ST_NEG = 3;
  localparam int ST_REPEAT = 4;
  localparam int ST_PRIO_LO = 5;
  localparam int ST_PRIO_HI = 7;
  localparam int ST_HALF = 8;

  // Control register field positions
  localparam int CT_WINDOW = 2;
  localparam int CT_PRIO_HIGH = 3;

  // Register selector values on the register port
  localparam logic SEL_STATUS = 1'h0;
  localparam logic SEL_CONTROL = 1'h1;

  // Values after reset
  localparam logic [2:0] PRIO_RST = 3'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic CTRL_BIT_RST = 1'h0;

  // Divide timing: setup, one step per divisor bit, sign fix, write back
  localparam int DIV_STEPS = 16;
  localparam int DIV_CYCLES = 19;
  localparam logic [4:0] DIV_LAST_STEP = 5'h0F;

  // Operations offered by the datapath
  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
    OP_ASR, OP_LSR, OP_SL,
    OP_MUL_SS, OP_MUL_UU, OP_MUL_SU, OP_MUL_US,
    OP_MUL_SLIT, OP_MUL_ULIT, OP_MUL_B8,
    OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16
  } cas_op_t;

  // One operation request
  typedef struct packed {
    cas_op_t op;                 // Operation
    logic byte_mode;             // 8-bit operand width
    logic mem_src;               // Operand came from data memory
    logic mem_dst;               // Result goes to data memory
    logic [3:0] dst_reg;         // Destination working register index
    logic [DATA_W-1:0] a;        // First operand, dividend low word
    logic [DATA_W-1:0] b;        // Second operand, divisor, literal or shift count
    logic [DATA_W-1:0] a_hi;     // Dividend high word for 32-bit divides
  } cas_req_t;

  // One datapath answer
  typedef struct packed {
    logic mem_dst;               // Write target is data memory
    logic [3:0] dst_reg;         // Destination working register index
    logic [DATA_W-1:0] lo;       // Result, or product low word
    logic [DATA_W-1:0] hi;       // Product high word
  } cas_res_t;

endpackage

// ===== logic/cas_alu_status.sv
// CPU ALU datapath with shifter, multiplier, iterative divider and status/control registers
`timescale 1ns/100ps

module cas_alu_status #(
  parameter int DATA_W = cas_pkg::DATA_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Operation request
  input wire logic req_valid,
  input wire cas_pkg::cas_req_t req,
  input wire logic div_abort,
  // Operation answer
  output logic res_valid,
  output cas_pkg::cas_res_t res,
  output logic req_illegal,
  // Divider
  output logic div_busy,
  output logic div_done,
  output logic [DATA_W-1:0] quotient_reg,
  output logic [DATA_W-1:0] remainder_reg,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_sel,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // Core state inputs
  input wire logic repeat_running,
  input wire logic nesting_disable,
  input wire logic prio_load,
  input wire logic [2:0] prio_value,
  input wire logic prio_high_set,
  // Status and control outputs
  output logic [DATA_W-1:0] alu_flags_reg,
  output logic [DATA_W-1:0] cpu_control_reg,
  output logic [3:0] eff_priority,
  output logic user_irq_block,
  output logic prog_window_enable
);

  // Refuse widths the flag and divide logic cannot serve
  initial begin
    if (DATA_W != 16) begin
      $error("cas_alu_status supports only a 16-bit datapath");
    end
  end

  // Divider sequencing states
  typedef enum logic [2:0] {DV_IDLE, DV_SETUP, DV_STEP, DV_FIX, DV_WRITE} cas_div_state_t;

  // Extend a 16-bit operand to the multiplier's 17 bits
  function automatic logic [16:0] ext17(input logic [15:0] v, input logic sgn);
    ext17 = {sgn & v[15], v};
  endfunction

  // Two's complement magnitude of a 32-bit value
  function automatic logic [31:0] mag32(input logic [31:0] v, input logic neg);
    mag32 = neg ? (~v + 32'h0000_0001) : v;
  endfunction

  // Flag registers
  logic carry_r, zero_r, wrap_r, neg_r, half_r;
  logic [2:0] prio_r;                      // Priority field
  logic high_r;                            // Priority high bit
  logic window_r;                          // Program window enable
  logic repeat_r;                          // Repeat loop mirror

  // Combinational ALU outcome
  logic [15:0] alu_lo, alu_hi;
  logic flags_upd, arith_upd;
  logic c_nxt, z_nxt, ov_nxt, n_nxt, dc_nxt;
  logic is_shift, is_mul, is_div, shift_bad;

  // Divider state
  cas_div_state_t dv_state_r;
  logic [4:0] dv_step_r;
  logic [16:0] dv_rem_r;                   // Partial remainder, one spare bit
  logic [15:0] dv_q_r;                     // Quotient bits shifting in
  logic [15:0] dv_divisor_r;
  logic [31:0] dv_dividend_r;
  logic dv_signed_r, dv_qneg_r, dv_rneg_r;
  logic [16:0] dv_trial;
  logic [31:0] dv_dvd_mag;                 // Dividend magnitude for setup
  logic [31:0] dv_dsr_mag;                 // Divisor magnitude for setup

  // Operation classes
  always_comb begin
    is_shift = (req.op == cas_pkg::OP_ASR) || (req.op == cas_pkg::OP_LSR) || (req.op == cas_pkg::OP_SL);
    is_mul = (req.op >= cas_pkg::OP_MUL_SS) && (req.op <= cas_pkg::OP_MUL_B8);
    is_div = (req.op >= cas_pkg::OP_DIV_S32);
    // Shifts have no memory addressing modes
    shift_bad = is_shift && (req.mem_src || req.mem_dst);
  end

  // Single-cycle arithmetic, logic, shift and multiply
  always_comb begin
    logic [15:0] bx;
    logic cin;
    logic [16:0] sw;
    logic [8:0] sb;
    logic [4:0] nib;
    logic [8:0] lowb;
    logic [16:0] ma, mb;
    logic [33:0] prod;
    logic [15:0] r;
    bx = req.b;
    cin = 1'h0;
    sw = 17'h0_0000;
    sb = 9'h000;
    nib = 5'h00;
    lowb = 9'h000;
    ma = 17'h0_0000;
    mb = 17'h0_0000;
    prod = 34'h0_0000_0000;
    r = 16'h0000;
    alu_lo = 16'h0000;
    alu_hi = 16'h0000;
    flags_upd = 1'h0;
    arith_upd = 1'h0;
    c_nxt = carry_r;
    dc_nxt = half_r;
    ov_nxt = wrap_r;
    // Subtraction adds the inverted operand plus one, carry means no borrow
    if (req.op == cas_pkg::OP_SUB) begin
      bx = ~req.b;
      cin = 1'h1;
    end
    sw = {1'h0, req.a} + {1'h0, bx} + {16'h0000, cin};
    sb = {1'h0, req.a[7:0]} + {1'h0, bx[7:0]} + {8'h00, cin};
    nib = {1'h0, req.a[3:0]} + {1'h0, bx[3:0]} + {4'h0, cin};
    lowb = sb;
    case (req.op)
      cas_pkg::OP_ADD, cas_pkg::OP_SUB: begin
        r = sw[15:0];
        flags_upd = 1'h1;
        arith_upd = 1'h1;
        if (req.byte_mode) begin
          c_nxt = sb[8];
          dc_nxt = nib[4];
          ov_nxt = (req.a[7] == bx[7]) && (sb[7] != req.a[7]);
        end else begin
          c_nxt = sw[16];
          dc_nxt = lowb[8];
          ov_nxt = (req.a[15] == bx[15]) && (sw[15] != req.a[15]);
        end
      end
      cas_pkg::OP_AND: begin
        r = req.a & req.b;
        flags_upd = 1'h1;
      end
      cas_pkg::OP_IOR: begin
        r = req.a | req.b;
        flags_upd = 1'h1;
      end
      cas_pkg::OP_XOR: begin
        r = req.a ^ req.b;
        flags_upd = 1'h1;
      end
      // Barrel shifts finish in the same cycle for any count 0..15
      cas_pkg::OP_ASR: begin
        r = 16'($signed(req.a) >>> req.b[cas_pkg::SHAMT_W-1:0]);
        flags_upd = 1'h1;
      end
      cas_pkg::OP_LSR: begin
        r = req.a >> req.b[cas_pkg::SHAMT_W-1:0];
        flags_upd = 1'h1;
      end
      cas_pkg::OP_SL: begin
        r = req.a << req.b[cas_pkg::SHAMT_W-1:0];
        flags_upd = 1'h1;
      end
      default: begin
        r = 16'h0000;
      end
    endcase
    // Multiplier operand preparation for each sign mode
    case (req.op)
      cas_pkg::OP_MUL_SS: begin
        ma = ext17(req.a, 1'h1);
        mb = ext17(req.b, 1'h1);
      end
      cas_pkg::OP_MUL_SU: begin
        ma = ext17(req.a, 1'h1);
        mb = ext17(req.b, 1'h0);
      end
      cas_pkg::OP_MUL_US: begin
        ma = ext17(req.a, 1'h0);
        mb = ext17(req.b, 1'h1);
      end
      cas_pkg::OP_MUL_SLIT: begin
        ma = ext17(req.a, 1'h1);
        mb = {12'h000, req.b[cas_pkg::LIT_W-1:0]};
      end
      cas_pkg::OP_MUL_ULIT: begin
        ma = ext17(req.a, 1'h0);
        mb = {12'h000, req.b[cas_pkg::LIT_W-1:0]};
      end
      cas_pkg::OP_MUL_B8: begin
        ma = {9'h000, req.a[7:0]};
        mb = {9'h000, req.b[7:0]};
      end
      default: begin
        ma = ext17(req.a, 1'h0);
        mb = ext17(req.b, 1'h0);
      end
    endcase
    // One signed 17x17 array serves every mode
    prod = 34'($signed(ma) * $signed(mb));
    if (is_mul) begin
      alu_lo = prod[15:0];
      alu_hi = (req.op == cas_pkg::OP_MUL_B8) ? 16'h0000 : prod[31:16];
    end else if (req.byte_mode && !is_shift) begin
      // Byte results leave the upper byte of the destination untouched
      alu_lo = {req.a[15:8], r[7:0]};
    end else begin
      alu_lo = r;
    end
    // Negative and zero follow the active width
    if (req.byte_mode && !is_shift) begin
      n_nxt = r[7];
      z_nxt = (r[7:0] == 8'h00);
    end else begin
      n_nxt = r[15];
      z_nxt = (r == 16'h0000);
    end
  end

  // Arithmetic and logic answers, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'h0;
      res <= '0;
      req_illegal <= 1'h0;
    end else begin
      res_valid <= req_valid && !is_div && !shift_bad;
      req_illegal <= req_valid && shift_bad;
      if (req_valid && !is_div) begin
        res.lo <= alu_lo;
        res.hi <= alu_hi;
        res.mem_dst <= req.mem_dst;
        res.dst_reg <= req.dst_reg;
      end
    end
  end

  // Status flags: hardware results win over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {half_r, neg_r, wrap_r, zero_r, carry_r} <= cas_pkg::FLAGS_RST;
    end else if (req_valid && flags_upd && !shift_bad) begin
      neg_r <= n_nxt;
      zero_r <= z_nxt;
      if (arith_upd) begin
        carry_r <= c_nxt;
        half_r <= dc_nxt;
        wrap_r <= ov_nxt;
      end
    end else if (reg_wr && reg_sel == cas_pkg::SEL_STATUS) begin
      carry_r <= reg_wdata[cas_pkg::ST_CARRY];
      zero_r <= reg_wdata[cas_pkg::ST_ZERO];
      wrap_r <= reg_wdata[cas_pkg::ST_WRAP];
      neg_r <= reg_wdata[cas_pkg::ST_NEG];
      half_r <= reg_wdata[cas_pkg::ST_HALF];
    end
  end

  // Priority field: hardware load wins, software blocked while nesting is disabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prio_r <= cas_pkg::PRIO_RST;
    end else if (prio_load) begin
      prio_r <= prio_value;
    end else if (reg_wr && reg_sel == cas_pkg::SEL_STATUS && !nesting_disable) begin
      prio_r <= reg_wdata[cas_pkg::ST_PRIO_HI:cas_pkg::ST_PRIO_LO];
    end
  end

  // Repeat flag mirrors the loop hardware, never software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_r <= 1'h0;
    end else begin
      repeat_r <= repeat_running;
    end
  end

  // Control bits: high bit is set by hardware and only cleared by software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_r <= cas_pkg::CTRL_BIT_RST;
      window_r <= cas_pkg::CTRL_BIT_RST;
    end else begin
      if (prio_high_set) begin
        high_r <= 1'h1;
      end else if (reg_wr && reg_sel == cas_pkg::SEL_CONTROL && !reg_wdata[cas_pkg::CT_PRIO_HIGH]) begin
        high_r <= 1'h0;
      end
      if (reg_wr && reg_sel == cas_pkg::SEL_CONTROL) begin
        window_r <= reg_wdata[cas_pkg::CT_WINDOW];
      end
    end
  end

  // Trial subtraction for one restoring divide step
  always_comb begin
    dv_trial = {dv_rem_r[15:0], dv_dividend_r[31]} - {1'h0, dv_divisor_r};
    // Magnitudes are formed here so setup can slice them
    dv_dvd_mag = mag32(dv_dividend_r, dv_signed_r && dv_dividend_r[31]);
    dv_dsr_mag = mag32({16'h0000, dv_divisor_r}, dv_signed_r && dv_divisor_r[15]);
  end

  // Divider: setup, sixteen steps, sign fix, write back; abort at any cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dv_state_r <= DV_IDLE;
      dv_step_r <= 5'h00;
      dv_rem_r <= 17'h0_0000;
      dv_q_r <= 16'h0000;
      dv_divisor_r <= 16'h0000;
      dv_dividend_r <= 32'h0000_0000;
      dv_signed_r <= 1'h0;
      dv_qneg_r <= 1'h0;
      dv_rneg_r <= 1'h0;
    end else if (div_abort) begin
      dv_state_r <= DV_IDLE;
    end else begin
      case (dv_state_r)
        DV_IDLE: begin
          if (req_valid && is_div) begin
            dv_signed_r <= (req.op == cas_pkg::OP_DIV_S32) || (req.op == cas_pkg::OP_DIV_S16);
            dv_divisor_r <= req.b;
            // Short dividends are widened so both sizes run the same steps
            case (req.op)
              cas_pkg::OP_DIV_S16: dv_dividend_r <= {{16{req.a[15]}}, req.a};
              cas_pkg::OP_DIV_U16: dv_dividend_r <= {16'h0000, req.a};
              default: dv_dividend_r <= {req.a_hi, req.a};
            endcase
            dv_state_r <= DV_SETUP;
          end
        end
        DV_SETUP: begin
          // Work on magnitudes, remember result signs
          dv_qneg_r <= dv_signed_r && (dv_dividend_r[31] ^ dv_divisor_r[15]);
          dv_rneg_r <= dv_signed_r && dv_dividend_r[31];
          dv_dividend_r <= {dv_dvd_mag[15:0], 16'h0000};
          dv_rem_r <= {1'h0, dv_dvd_mag[31:16]};
          dv_divisor_r <= dv_dsr_mag[15:0];
          dv_step_r <= 5'h00;
          dv_state_r <= DV_STEP;
        end
        DV_STEP: begin
          // One quotient bit per divisor bit
          if (!dv_trial[16]) begin
            dv_rem_r <= dv_trial;
            dv_q_r <= {dv_q_r[14:0], 1'h1};
          end else begin
            dv_rem_r <= {dv_rem_r[15:0], dv_dividend_r[31]};
            dv_q_r <= {dv_q_r[14:0], 1'h0};
          end
          dv_dividend_r <= {dv_dividend_r[30:0], 1'h0};
          dv_step_r <= dv_step_r + 5'h01;
          if (dv_step_r == cas_pkg::DIV_LAST_STEP) begin
            dv_state_r <= DV_FIX;
          end
        end
        DV_FIX: begin
          dv_q_r <= dv_qneg_r ? (~dv_q_r + 16'h0001) : dv_q_r;
          dv_rem_r <= {1'h0, dv_rneg_r ? (~dv_rem_r[15:0] + 16'h0001) : dv_rem_r[15:0]};
          dv_state_r <= DV_WRITE;
        end
        DV_WRITE: begin
          dv_state_r <= DV_IDLE;
        end
        default: begin
          dv_state_r <= DV_IDLE;
        end
      endcase
    end
  end

  // Divide results land in the fixed quotient and remainder registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      quotient_reg <= 16'h0000;
      remainder_reg <= 16'h0000;
      div_done <= 1'h0;
      div_busy <= 1'h0;
    end else begin
      div_done <= 1'h0;
      if (div_abort) begin
        div_busy <= 1'h0;
      end else if (dv_state_r == DV_IDLE && req_valid && is_div) begin
        div_busy <= 1'h1;
      end else if (dv_state_r == DV_WRITE) begin
        quotient_reg <= dv_q_r;
        remainder_reg <= dv_rem_r[15:0];
        div_done <= 1'h1;
        div_busy <= 1'h0;
      end
    end
  end

  // Register read data; unimplemented bits are zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= (reg_sel == cas_pkg::SEL_STATUS) ? alu_flags_reg : cpu_control_reg;
    end
  end

  // Assembled register images and priority view, all from flip-flops
  always_comb begin
    alu_flags_reg = {7'h00, half_r, prio_r, repeat_r, neg_r, wrap_r, zero_r, carry_r};
    cpu_control_reg = {12'h000, high_r, window_r, 2'h0};
    eff_priority = {high_r, prio_r};
    user_irq_block = high_r;
    prog_window_enable = window_r;
  end

endmodule

// ===== testbench/cas_alu_status_chk.sv
// Port checker for the ALU status datapath, bound to the top module
`timescale 1ns/100ps
module cas_alu_status_chk #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Requests and core state
  input wire logic req_valid,
  input wire cas_pkg::cas_req_t req,
  input wire logic prio_load,
  input wire logic nesting_disable,
  input wire logic repeat_running,
  // Answers and registers
  input wire logic res_valid,
  input wire logic req_illegal,
  input wire logic div_busy,
  input wire logic div_done,
  input wire logic [DATA_W-1:0] alu_flags_reg,
  input wire logic [DATA_W-1:0] cpu_control_reg,
  input wire logic [3:0] eff_priority,
  input wire logic user_irq_block,
  input wire logic prog_window_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] busy_cnt_r; // Busy cycles of the current divide
  logic [16:0] add_sum; // Word add with carry out
  logic add_carry; // Carry out of that add
  logic is_shift; // Multi-bit shift request
  logic is_div; // Divide request
  logic bad_shift; // Shift asking for memory operands
  assign add_sum = {1'b0, req.a} + {1'b0, req.b};
  assign add_carry = add_sum[16];
  assign is_shift = req.op inside {cas_pkg::OP_ASR, cas_pkg::OP_LSR, cas_pkg::OP_SL};
  assign is_div = req.op inside {cas_pkg::OP_DIV_S32, cas_pkg::OP_DIV_U32, cas_pkg::OP_DIV_S16, cas_pkg::OP_DIV_U16};
  assign bad_shift = is_shift && (req.mem_src || req.mem_dst);
  // Count busy cycles; an idle divider clears the count so aborts leave no trace
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_r <= 5'h00;
    end else if (div_busy) begin
      busy_cnt_r <= busy_cnt_r + 5'h01;
    end else begin
      busy_cnt_r <= 5'h00;
    end
  end
  unimpl_zero_a: assert property (
    alu_flags_reg[15:9] == 7'h00 && cpu_control_reg[15:4] == 12'h000 && cpu_control_reg[1:0] == 2'h0)
    else $error("unimplemented register bits not zero");
  eff_prio_a: assert property (
    eff_priority == {cpu_control_reg[3], alu_flags_reg[7:5]}) else $error("effective priority mismatch");
  irq_block_a: assert property (
    user_irq_block == cpu_control_reg[3]) else $error("user interrupt block mismatch");
  window_en_a: assert property (
    prog_window_enable == cpu_control_reg[2]) else $error("program window enable mismatch");
  repeat_mirror_a: assert property (
    $past(rst_n) |-> alu_flags_reg[4] == $past(repeat_running)) else $error("repeat flag does not follow loop");
  prio_lock_a: assert property (
    $past(rst_n) && $past(nesting_disable) && !$past(prio_load) |-> $stable(alu_flags_reg[7:5]))
    else $error("priority field changed while locked");
  div_len_a: assert property (
    div_done |-> busy_cnt_r == 5'h13) else $error("divide length wrong");
  div_start_a: assert property (
    req_valid && is_div && !div_busy |=> div_busy ##1 div_busy) else $error("divide not started");
  shift_refuse_a: assert property (
    req_valid && bad_shift |=> req_illegal && !res_valid) else $error("memory shift not refused");
  op_answer_a: assert property (
    req_valid && !is_div && !bad_shift |=> res_valid && !req_illegal) else $error("missing single cycle answer");
  add_carry_a: assert property (
    req_valid && req.op == cas_pkg::OP_ADD && !req.byte_mode |=> alu_flags_reg[0] == $past(add_carry))
    else $error("carry flag wrong after add");
endmodule

bind cas_alu_status cas_alu_status_chk #(.DATA_W(DATA_W)) cas_alu_status_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .prio_load(prio_load),
  .nesting_disable(nesting_disable), .repeat_running(repeat_running), .res_valid(res_valid),
  .req_illegal(req_illegal), .div_busy(div_busy), .div_done(div_done), .alu_flags_reg(alu_flags_reg),
  .cpu_control_reg(cpu_control_reg), .eff_priority(eff_priority), .user_irq_block(user_irq_block),
  .prog_window_enable(prog_window_enable));

// ===== testbench/cas_alu_status_tb.sv
// Self-checking bench for the ALU status datapath
`timescale 1ns/100ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module cas_alu_status_tb;
  logic sys_clk = 1'b0; // 25 MHz core clock
  logic rst_n = 1'b0; // Active low reset
  logic req_valid = 1'b0, div_abort = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_sel = 1'b0;
  logic repeat_running = 1'b0, nesting_disable = 1'b0, prio_load = 1'b0, prio_high_set = 1'b0;
  logic [2:0] prio_value = 3'h0; // Hardware priority load value
  logic [15:0] reg_wdata = 16'h0000; // Register write data
  cas_pkg::cas_req_t req = '0; // Operation request
  cas_pkg::cas_res_t res; // Operation answer
  logic res_valid, req_illegal, div_busy, div_done, user_irq_block, prog_window_enable;
  logic [15:0] quotient_reg, remainder_reg, reg_rdata, alu_flags_reg, cpu_control_reg;
  logic [3:0] eff_priority; // Concatenated priority
  cas_pkg::cas_req_t ill; // Refused shift request, later the aborted divide request
  int err_total = 0; // Mismatches
  int total_checks = 0; // Comparisons
  int n; // Cycle counter for waits
  cas_alu_status cas_alu_status_inst (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .div_abort(div_abort), .res_valid(res_valid), .res(res), .req_illegal(req_illegal), .div_busy(div_busy),
    .div_done(div_done), .quotient_reg(quotient_reg), .remainder_reg(remainder_reg), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .repeat_running(repeat_running), .nesting_disable(nesting_disable), .prio_load(prio_load),
    .prio_value(prio_value), .prio_high_set(prio_high_set), .alu_flags_reg(alu_flags_reg),
    .cpu_control_reg(cpu_control_reg), .eff_priority(eff_priority), .user_irq_block(user_irq_block),
    .prog_window_enable(prog_window_enable));
  // Clock: half period 20 ns
  always #20 sys_clk = ~sys_clk;
  // Verdict and end of run
  task summarize();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Register write; value visible one edge later
  task reg_write(input logic sel, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_sel <= sel;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Register read and compare
  task reg_read(input logic sel, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_sel <= sel;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  // Single-cycle operation; only flags under the mask are compared
  task run_op(input cas_pkg::cas_op_t op, input logic bm, input logic [15:0] a, b, lo, hi, msk, flg);
    cas_pkg::cas_req_t r;
    r = '0;
    r.op = op;
    r.byte_mode = bm;
    r.a = a;
    r.b = b;
    r.dst_reg = a[3:0];
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= r;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    `CHK(res_valid, 1'b1)
    `CHK(res.lo, lo)
    `CHK(res.dst_reg, r.dst_reg)
    `CHK(alu_flags_reg & msk, flg)
    if (op inside {cas_pkg::OP_MUL_SS, cas_pkg::OP_MUL_UU, cas_pkg::OP_MUL_SU, cas_pkg::OP_MUL_US,
        cas_pkg::OP_MUL_SLIT, cas_pkg::OP_MUL_ULIT, cas_pkg::OP_MUL_B8}) begin
      `CHK(res.hi, hi)
    end
  endtask
  // Divide; the wait is bounded, so a stuck divider ends the run
  task run_div(input cas_pkg::cas_op_t op, input logic [15:0] ahi, a, b, q, rm);
    cas_pkg::cas_req_t r;
    r = '0;
    r.op = op;
    r.a_hi = ahi;
    r.a = a;
    r.b = b;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= r;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    n = 0;
    while (div_done !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 40) begin
      err_total++;
      summarize();
    end
    `CHK(n, cas_pkg::DIV_CYCLES)
    `CHK(quotient_reg, q)
    `CHK(remainder_reg, rm)
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    `CHK(alu_flags_reg, 16'h0000)
    `CHK(cpu_control_reg, 16'h0000)
    reg_write(1'b0, 16'hFFFF);
    `CHK(alu_flags_reg, 16'h01EF)
    `CHK(eff_priority, 4'h7)
    reg_read(1'b0, 16'h01EF);
    reg_write(1'b1, 16'hFFFF);
    `CHK(cpu_control_reg, 16'h0004)
    `CHK(prog_window_enable, 1'b1)
    @(posedge sys_clk);
    prio_high_set <= 1'b1;
    @(posedge sys_clk);
    prio_high_set <= 1'b0;
    #1;
    `CHK(eff_priority, 4'hF)
    `CHK(user_irq_block, 1'b1)
    reg_read(1'b1, 16'h000C);
    reg_write(1'b1, 16'h0000);
    `CHK(cpu_control_reg, 16'h0000)
    @(posedge sys_clk);
    nesting_disable <= 1'b1;
    reg_write(1'b0, 16'h0000);
    `CHK(alu_flags_reg, 16'h00E0)
    @(posedge sys_clk);
    prio_load <= 1'b1;
    prio_value <= 3'h2;
    @(posedge sys_clk);
    prio_load <= 1'b0;
    nesting_disable <= 1'b0;
    #1;
    `CHK(alu_flags_reg[7:5], 3'h2)
    reg_write(1'b0, 16'h0000);
    `CHK(alu_flags_reg, 16'h0000)
    @(posedge sys_clk);
    repeat_running <= 1'b1;
    reg_write(1'b0, 16'h0000);
    `CHK(alu_flags_reg, 16'h0010)
    @(posedge sys_clk);
    repeat_running <= 1'b0;
    // Flags: add/sub affect DC,N,OV,Z,C; logic and shifts N,Z; products none
    run_op(cas_pkg::OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 0, 16'h010F, 16'h010C);
    run_op(cas_pkg::OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 0, 16'h010F, 16'h0103);
    run_op(cas_pkg::OP_ADD, 1'b1, 16'h120F, 16'h0001, 16'h1210, 0, 16'h010F, 16'h0100);
    run_op(cas_pkg::OP_ADD, 1'b1, 16'h0080, 16'h0080, 16'h0000, 0, 16'h010F, 16'h0007);
    run_op(cas_pkg::OP_ADD, 1'b1, 16'h0070, 16'h0010, 16'h0080, 0, 16'h010F, 16'h000C);
    run_op(cas_pkg::OP_SUB, 1'b0, 16'h0005, 16'h0007, 16'hFFFE, 0, 16'h010F, 16'h0008);
    run_op(cas_pkg::OP_SUB, 1'b0, 16'h8000, 16'h0001, 16'h7FFF, 0, 16'h010F, 16'h0005);
    run_op(cas_pkg::OP_AND, 1'b0, 16'hF0F0, 16'h0FF0, 16'h00F0, 0, 16'h000A, 16'h0000);
    run_op(cas_pkg::OP_IOR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 0, 16'h000A, 16'h0008);
    run_op(cas_pkg::OP_XOR, 1'b0, 16'h5555, 16'h5555, 16'h0000, 0, 16'h000A, 16'h0002);
    run_op(cas_pkg::OP_ASR, 1'b0, 16'h8000, 16'h000F, 16'hFFFF, 0, 16'h000A, 16'h0008);
    run_op(cas_pkg::OP_LSR, 1'b0, 16'h8000, 16'h000F, 16'h0001, 0, 16'h000A, 16'h0000);
    run_op(cas_pkg::OP_SL, 1'b0, 16'h0001, 16'h000F, 16'h8000, 0, 16'h000A, 16'h0008);
    run_op(cas_pkg::OP_MUL_SS, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000, 0, 0);
    run_op(cas_pkg::OP_MUL_UU, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0001, 16'hFFFE, 0, 0);
    run_op(cas_pkg::OP_MUL_SU, 1'b0, 16'hFFFF, 16'h0002, 16'hFFFE, 16'hFFFF, 0, 0);
    run_op(cas_pkg::OP_MUL_US, 1'b0, 16'hFFFF, 16'h0002, 16'hFFFE, 16'h0001, 0, 0);
    run_op(cas_pkg::OP_MUL_SLIT, 1'b0, 16'hFFFE, 16'h001F, 16'hFFC2, 16'hFFFF, 0, 0);
    run_op(cas_pkg::OP_MUL_ULIT, 1'b0, 16'hFFFE, 16'h001F, 16'hFFC2, 16'h001E, 0, 0);
    run_op(cas_pkg::OP_MUL_B8, 1'b0, 16'h00FF, 16'h00FF, 16'hFE01, 16'h0000, 0, 0);
    // Shift with a memory operand must be refused outright
    ill = '0;
    ill.op = cas_pkg::OP_SL;
    ill.mem_dst = 1'b1;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= ill;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    `CHK(req_illegal, 1'b1)
    `CHK(res_valid, 1'b0)
    run_div(cas_pkg::OP_DIV_S32, 16'hFFFF, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
    run_div(cas_pkg::OP_DIV_U32, 16'h0001, 16'h0005, 16'h0010, 16'h1000, 16'h0005);
    run_div(cas_pkg::OP_DIV_S16, 16'h0000, 16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF);
    run_div(cas_pkg::OP_DIV_U16, 16'h0000, 16'hFFF9, 16'h0002, 16'h7FFC, 16'h0001);
    // Abort mid-divide: no completion, results untouched
    ill = '0;
    ill.op = cas_pkg::OP_DIV_U16;
    ill.a = 16'h0009;
    ill.b = 16'h0003;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= ill;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    repeat (5) @(posedge sys_clk);
    div_abort <= 1'b1;
    @(posedge sys_clk);
    div_abort <= 1'b0;
    n = 0;
    repeat (25) begin
      @(posedge sys_clk);
      #1;
      n += int'(div_done === 1'b1);
    end
    `CHK(n, 0)
    `CHK(div_busy, 1'b0)
    `CHK(quotient_reg, 16'h7FFC)
    summarize();
  end
endmodule
